/* include/rtc_pkg.sv */
// Package: constants and carrier types for the divisional trip coincidence logic
//
// Function
// - Compare each analog variable against own setpoint
// - Discrete bistable inputs pass without setpoint compare
// - Every division trip bit reaches all units
// - Two-of-four vote per variable, OR result
// - Neutron monitor bits voted by same rule
// - One sensor division bypassed gives two-of-three
// - Bypass units handle sensor and vote bypass
// - Output latch: trip, seal-in, reset, test
// - Division trip drives only own actuators
// - Load drivers combine two-of-four, two arrangements
// - Tripped load driver is de-energized output
// - Backup relay coil drops, dump valve energizes
// - Relay logic gives reset permissive, rod run-in
// - Turbine valve trips only above forty percent; the code also enables them when any division's power reading is invalid
// - Steam line isolation trip counts in Run only
// - Trip inputs list of listed plant variables
// - Bypass and setpoint changes need access enable
// - Staged testing allowed on-line and off-line
// - Reset needs operator action, plus the delay after a full scram
// - Manual trip: both switches or shutdown mode
// - Lost power or input forces trip state
// - Backup scram and run-in only on full scram
`default_nettype none
package rtc_pkg;
    localparam int NDIV = 4;
    localparam int NANA = 5;
    localparam int NDISC = 4;
    localparam int NVAR = NANA + NDISC + 1;
    localparam int AW = 16;
    // Analog variable indices
    localparam int AN_PRESS = 0;
    localparam int AN_LEVEL = 1;
    localparam int AN_DRYWELL = 2;
    localparam int AN_ACCUM = 3;
    localparam int AN_POWER = 4;
    // Discrete variable indices
    localparam int DI_STOPV = 0;
    localparam int DI_CTRLV = 1;
    localparam int DI_RAD = 2;
    localparam int DI_STEAM_LINE_ISOLATION_TRIP = 3;
    // Trip direction per analog: 1 means trips when above setpoint
    localparam logic [NANA-1:0] AN_HIGH_TRIP = 5'h15;
    localparam logic [AW-1:0] POWER_PERMISSIVE = 16'h0028;
    localparam int SEAL_TIME_MS = 10;
    localparam int CLK_KHZ = 100000;
    localparam int SEAL_CYCLES = SEAL_TIME_MS * CLK_KHZ;
    localparam logic [3:0] MODE_SHUTDOWN = 4'h1;
    localparam logic [3:0] MODE_RUN = 4'h8;
    localparam logic [NDIV-1:0] BYP_NONE = 4'h0;

    typedef struct packed {
        logic [NANA-1:0][AW-1:0] value;
        logic [NANA-1:0] valid;
        logic [NDISC-1:0] discrete;
        logic flux_trip;
    } rtc_div_in_t;

    typedef struct packed {
        logic [NDIV-1:0] load_driver_on;
        logic [NDIV-1:0] backup_relay_coil;
        logic scram_bus_a_on;
        logic scram_bus_b_on;
        logic dump_valve_on;
        logic rod_run_in;
        logic reset_permissive;
    } rtc_act_t;
endpackage
`default_nettype wire

/* rtl/rtc_setpoint_mem.sv */
// Setpoint store: one word per division and analog variable, registered read
`default_nettype none
module rtc_setpoint_mem #(
    parameter int DEPTH = rtc_pkg::NDIV * rtc_pkg::NANA,
    parameter int AW = rtc_pkg::AW,
    parameter int IW = 5
) (
    input wire logic ref_clk,
    input wire logic ce,
    input wire logic wr_en,
    input wire logic [IW-1:0] wr_idx,
    input wire logic [AW-1:0] wr_data,
    output logic [DEPTH-1:0][AW-1:0] rd_data
);
    logic [DEPTH-1:0][AW-1:0] mem;

    always_ff @(posedge ref_clk)
    begin
        if (ce)
        begin
            if (wr_en && wr_idx < IW'(DEPTH))
            begin
                mem[wr_idx] <= wr_data;
            end
            rd_data <= mem;
        end
    end
endmodule
`default_nettype wire

/* rtl/rtc_trip_logic.sv */
// Four-division trip coincidence, bypass, output latch and scram combining logic
`default_nettype none
module rtc_trip_logic #(
    parameter int SEAL_CYCLES = rtc_pkg::SEAL_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ce,
    input wire rtc_pkg::rtc_div_in_t [rtc_pkg::NDIV-1:0] div_in,
    input wire logic [rtc_pkg::NDIV-1:0] power_ok,
    input wire logic [3:0] mode_sel,
    input wire logic manual_sw_a,
    input wire logic manual_sw_b,
    input wire logic access_enable,
    input wire logic sensor_byp_req,
    input wire logic sensor_byp_clr,
    input wire logic [1:0] sensor_byp_div,
    input wire logic vote_byp_req,
    input wire logic vote_byp_clr,
    input wire logic [1:0] vote_byp_div,
    input wire logic sp_wr,
    input wire logic [4:0] sp_idx,
    input wire logic [rtc_pkg::AW-1:0] sp_data,
    input wire logic [rtc_pkg::NDIV-1:0] test_trip,
    input wire logic operator_reset,
    output rtc_pkg::rtc_act_t act,
    output logic [rtc_pkg::NDIV-1:0] div_tripped,
    output logic [rtc_pkg::NDIV-1:0] sensor_byp_state,
    output logic [rtc_pkg::NDIV-1:0] vote_byp_state,
    output logic byp_rejected,
    output logic full_scram
);
    localparam int NDIV = rtc_pkg::NDIV;
    localparam int NANA = rtc_pkg::NANA;
    localparam int NVAR = rtc_pkg::NVAR;
    localparam int DW = $bits(rtc_pkg::rtc_div_in_t);
    localparam int CW = $clog2(SEAL_CYCLES + 1);

    typedef struct packed {
        logic [NDIV-1:0][DW-1:0] in_s1;
        logic [NDIV-1:0][DW-1:0] in_s2;
        logic [NDIV-1:0] pwr_s1;
        logic [NDIV-1:0] pwr_s2;
        logic [3:0] mode_s1;
        logic [3:0] mode_s2;
        logic [1:0] man_s1;
        logic [1:0] man_s2;
        logic [NDIV-1:0][NVAR-1:0] var_trip;
        logic [NDIV-1:0] vote;
        logic [NDIV-1:0] latch;
        logic [NDIV-1:0] sbyp;
        logic [NDIV-1:0] vbyp;
        logic rej;
        logic scram;
        logic [CW-1:0] seal_cnt;
    } rtc_state_t;

    rtc_state_t st_r;
    rtc_state_t st_nxt;
    logic [NDIV*NANA-1:0][rtc_pkg::AW-1:0] setpoints;

    rtc_setpoint_mem #(
        .DEPTH(NDIV * NANA),
        .AW(rtc_pkg::AW),
        .IW(5)
    ) u_sp (
        .ref_clk(ref_clk),
        .ce(ce),
        .wr_en(sp_wr && access_enable),
        .wr_idx(sp_idx),
        .wr_data(sp_data),
        .rd_data(setpoints)
    );

    // Count of set bits among four
    function automatic logic [2:0] pop4(input logic [NDIV-1:0] v);
        pop4 = 3'(v[0]) + 3'(v[1]) + 3'(v[2]) + 3'(v[3]);
    endfunction

    // Coincidence test: two-of-four, or two-of-three with a division removed
    function automatic logic coincide(input logic [NDIV-1:0] v, input logic [NDIV-1:0] byp);
        coincide = pop4(v & ~byp) >= 3'h2;
    endfunction

    rtc_pkg::rtc_div_in_t [NDIV-1:0] din;
    logic [NDIV-1:0][NVAR-1:0] var_trip_c;
    logic run_mode;
    logic above_power;
    logic manual_trip;
    logic [NVAR-1:0][NDIV-1:0] var_by_div;
    logic [NVAR-1:0] var_vote;

    assign run_mode = st_r.mode_s2 == rtc_pkg::MODE_RUN;
    assign manual_trip = (&st_r.man_s2) || st_r.mode_s2 == rtc_pkg::MODE_SHUTDOWN;

    // Power permissive shared: any division above it, or with a bad reading, counts as high power
    always_comb
    begin
        above_power = 1'b0;
        for (int d = 0; d < NDIV; d++)
        begin
            din[d] = rtc_pkg::rtc_div_in_t'(st_r.in_s2[d]);
            if (!din[d].valid[rtc_pkg::AN_POWER] ||
                din[d].value[rtc_pkg::AN_POWER] > rtc_pkg::POWER_PERMISSIVE)
            begin
                above_power = 1'b1;
            end
        end
    end

    genvar gd;
    genvar ga;
    generate
        for (gd = 0; gd < NDIV; gd++)
        begin : g_div
            for (ga = 0; ga < NANA; ga++)
            begin : g_ana
                logic over;
                assign over = din[gd].value[ga] > setpoints[gd*NANA+ga];
                // Invalid or unpowered inputs trip the variable
                assign var_trip_c[gd][ga] = !st_r.pwr_s2[gd] || !din[gd].valid[ga] ||
                    (rtc_pkg::AN_HIGH_TRIP[ga] ? over :
                    din[gd].value[ga] < setpoints[gd*NANA+ga]);
            end
            // Discrete bistable bits used directly, with mode and power permissives
            assign var_trip_c[gd][NANA+rtc_pkg::DI_STOPV] = !st_r.pwr_s2[gd] ||
                (din[gd].discrete[rtc_pkg::DI_STOPV] && above_power);
            assign var_trip_c[gd][NANA+rtc_pkg::DI_CTRLV] = !st_r.pwr_s2[gd] ||
                (din[gd].discrete[rtc_pkg::DI_CTRLV] && above_power);
            assign var_trip_c[gd][NANA+rtc_pkg::DI_RAD] = !st_r.pwr_s2[gd] ||
                din[gd].discrete[rtc_pkg::DI_RAD];
            assign var_trip_c[gd][NANA+rtc_pkg::DI_STEAM_LINE_ISOLATION_TRIP] = !st_r.pwr_s2[gd] ||
                (din[gd].discrete[rtc_pkg::DI_STEAM_LINE_ISOLATION_TRIP] && run_mode);
            assign var_trip_c[gd][NVAR-1] = !st_r.pwr_s2[gd] || din[gd].flux_trip;
        end
    endgenerate

    // Every division's bits go to the shared vote; all units see the same set
    always_comb
    begin
        for (int v = 0; v < NVAR; v++)
        begin
            for (int d = 0; d < NDIV; d++)
            begin
                var_by_div[v][d] = st_r.var_trip[d][v];
            end
            var_vote[v] = coincide(var_by_div[v], st_r.sbyp);
        end
    end

    logic any_vote;
    logic [NDIV-1:0] eff_trip;
    logic [NDIV-1:0] drv_trip;
    logic seal_done;
    logic one_sbyp;
    logic one_vbyp;

    assign any_vote = |var_vote;
    assign seal_done = st_r.seal_cnt == CW'(SEAL_CYCLES);
    assign one_sbyp = st_r.sbyp != rtc_pkg::BYP_NONE;
    assign one_vbyp = st_r.vbyp != rtc_pkg::BYP_NONE;
    // A vote-bypassed unit's output is ignored by the load driver combination
    assign drv_trip = st_r.latch & ~st_r.vbyp;

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.in_s1 = div_in;
        st_nxt.in_s2 = st_r.in_s1;
        st_nxt.pwr_s1 = power_ok;
        st_nxt.pwr_s2 = st_r.pwr_s1;
        st_nxt.mode_s1 = mode_sel;
        st_nxt.mode_s2 = st_r.mode_s1;
        st_nxt.man_s1 = {manual_sw_b, manual_sw_a};
        st_nxt.man_s2 = st_r.man_s1;
        st_nxt.var_trip = var_trip_c;
        st_nxt.rej = 1'b0;
        for (int d = 0; d < NDIV; d++)
        begin
            st_nxt.vote[d] = any_vote;
        end
        // Bypass units, gated by access enable, one division at a time
        if (sensor_byp_clr && access_enable)
        begin
            st_nxt.sbyp = rtc_pkg::BYP_NONE;
        end
        else if (sensor_byp_req && access_enable)
        begin
            if (one_sbyp)
            begin
                st_nxt.rej = 1'b1;
            end
            else
            begin
                st_nxt.sbyp = 4'h1 << sensor_byp_div;
            end
        end
        else if (sensor_byp_req)
        begin
            st_nxt.rej = 1'b1;
        end
        if (vote_byp_clr && access_enable)
        begin
            st_nxt.vbyp = rtc_pkg::BYP_NONE;
        end
        else if (vote_byp_req && access_enable)
        begin
            if (one_vbyp)
            begin
                st_nxt.rej = 1'b1;
            end
            else
            begin
                st_nxt.vbyp = 4'h1 << vote_byp_div;
            end
        end
        else if (vote_byp_req)
        begin
            st_nxt.rej = 1'b1;
        end
        // Output latches: trip seals in until a deliberate reset, timed only after a full scram
        for (int d = 0; d < NDIV; d++)
        begin
            eff_trip[d] = st_r.vote[d] || manual_trip || test_trip[d] || !st_r.pwr_s2[d];
            if (eff_trip[d])
            begin
                st_nxt.latch[d] = 1'b1;
            end
            // Without a full scram there is no run-in to wait for
            else if (operator_reset && (seal_done || !st_r.scram))
            begin
                st_nxt.latch[d] = 1'b0;
            end
        end
        st_nxt.scram = pop4(drv_trip) >= 3'h2;
        if (st_r.scram && st_nxt.scram)
        begin
            st_nxt.scram = 1'b1;
        end
        else if (st_r.scram && !(operator_reset && seal_done))
        begin
            st_nxt.scram = 1'b1;
        end
        if (!st_r.scram)
        begin
            st_nxt.seal_cnt = '0;
        end
        else if (!seal_done)
        begin
            st_nxt.seal_cnt = st_r.seal_cnt + CW'(1);
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            st_r <= '0;
            st_r.latch <= 4'hF;
            st_r.scram <= 1'b1;
        end
        else if (ce)
        begin
            st_r <= st_nxt;
        end
    end

    // Actuators: energized means healthy; trip drops drive, but a scram energizes dump valve and rod run-in, and reset permissive after the delay
    always_comb
    begin
        act.load_driver_on = ~st_r.latch;
        act.backup_relay_coil = ~st_r.latch;
        act.scram_bus_a_on = !st_r.scram;
        act.scram_bus_b_on = !st_r.scram;
        act.dump_valve_on = st_r.scram;
        act.rod_run_in = st_r.scram;
        act.reset_permissive = st_r.scram && seal_done;
    end

    assign div_tripped = st_r.latch;
    assign sensor_byp_state = st_r.sbyp;
    assign vote_byp_state = st_r.vbyp;
    assign byp_rejected = st_r.rej;
    assign full_scram = st_r.scram;
endmodule
`default_nettype wire

/* test/rtc_plant_model.sv */
// Plant sensor model: builds each division's inputs from a trip pattern
`default_nettype none
module rtc_plant_model (
    input wire logic [3:0] trip_var,
    input wire logic [3:0] div_mask,
    input wire logic pwr_hi,
    output rtc_pkg::rtc_div_in_t [rtc_pkg::NDIV-1:0] div_in
);
    timeunit 1ns;
    timeprecision 1ps;
    always_comb
    begin
        for (int d = 0; d < rtc_pkg::NDIV; d++)
        begin
            for (int j = 0; j < rtc_pkg::NANA; j++)
            begin
                if (div_mask[d] && trip_var == 4'(j))
                    div_in[d].value[j] = rtc_pkg::AN_HIGH_TRIP[j] ? 16'hF000 : 16'h0100;
                else
                    div_in[d].value[j] = rtc_pkg::AN_HIGH_TRIP[j] ? 16'h1000 : 16'hC000;
            end
            // Low power keeps the turbine valve trips disabled
            if (!pwr_hi && !(div_mask[d] && trip_var == 4'h4))
                div_in[d].value[4] = 16'h0010;
            div_in[d].valid = 5'h1F;
            div_in[d].discrete = div_mask[d] ? 4'h1 << (trip_var - 4'h5) : 4'h0;
            div_in[d].flux_trip = div_mask[d] && trip_var == 4'h9;
        end
    end
endmodule
`default_nettype wire

/* test/rtc_trip_logic_sva.sv */
// Checker for the trip coincidence logic ports
`default_nettype none
module rtc_trip_logic_sva #(
    parameter int SEAL_CYCLES = 8
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic operator_reset,
    input wire rtc_pkg::rtc_act_t act,
    input wire logic [rtc_pkg::NDIV-1:0] div_tripped,
    input wire logic [rtc_pkg::NDIV-1:0] sensor_byp_state,
    input wire logic [rtc_pkg::NDIV-1:0] vote_byp_state,
    input wire logic full_scram
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    a_reset_trip: assert property (disable iff (1'b0) rst |=> full_scram && div_tripped == 4'hF && act.load_driver_on == 4'h0)
        else $error("reset did not leave all paths tripped");
    a_backup_coil: assert property (act.backup_relay_coil == ~div_tripped)
        else $error("backup relay coil not dropped on trip");
    a_bus_a_drop: assert property (act.scram_bus_a_on == !full_scram)
        else $error("scram bus a wrong for scram state");
    a_bus_b_drop: assert property (act.scram_bus_b_on == !full_scram)
        else $error("scram bus b wrong for scram state");
    a_dump_valve: assert property (act.dump_valve_on == full_scram)
        else $error("dump valve not following scram");
    a_rod_run_in: assert property (act.rod_run_in == full_scram)
        else $error("rod run-in not following scram");
    a_permit_scram: assert property (act.reset_permissive |-> full_scram)
        else $error("reset permissive without scram");
    a_clear_permit: assert property ($fell(full_scram) |-> $past(act.reset_permissive))
        else $error("scram cleared without permissive");
    a_two_div_scram: assert property ($countones(div_tripped & ~vote_byp_state) >= 2 && !operator_reset |=> full_scram)
        else $error("two tripped divisions gave no scram");
    a_byp_single: assert property ($onehot0(sensor_byp_state) && $onehot0(vote_byp_state))
        else $error("more than one division bypassed");
endmodule
bind rtc_trip_logic rtc_trip_logic_sva #(.SEAL_CYCLES(SEAL_CYCLES)) u_sva (
    .ref_clk(ref_clk), .rst(rst), .operator_reset(operator_reset), .act(act),
    .div_tripped(div_tripped), .sensor_byp_state(sensor_byp_state),
    .vote_byp_state(vote_byp_state), .full_scram(full_scram));
`default_nettype wire

/* test/rtc_trip_logic_test.sv */
// Self-checking bench for the trip coincidence logic
`default_nettype none
module rtc_trip_logic_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0, rst = 1'b1, access_enable = 1'b0, operator_reset = 1'b0;
    logic sp_wr = 1'b0, pwr = 1'b1, byp_rejected, full_scram;
    logic [4:0] sp_idx = 5'h00;
    logic [15:0] sp_data = 16'h0000;
    logic [3:0] br = 4'h0, mask = 4'h0, var_i = 4'h0, pok = 4'hF, tt = 4'h0, sb = 4'h0;
    logic [3:0] mode = 4'h8, div_tripped, sbs, vbs;
    logic [1:0] bd = 2'h0, man = 2'h0;
    int n_mismatch = 0, checked = 0;
    rtc_pkg::rtc_div_in_t [rtc_pkg::NDIV-1:0] div_in;
    rtc_pkg::rtc_act_t act;
    always #5 ref_clk = ~ref_clk;
    rtc_plant_model model (.trip_var(var_i), .div_mask(mask), .pwr_hi(pwr), .div_in(div_in));
    rtc_trip_logic #(.SEAL_CYCLES(8)) dut (.ref_clk(ref_clk), .rst(rst), .ce(1'b1),
        .div_in(div_in), .power_ok(pok), .mode_sel(mode), .manual_sw_a(man[0]),
        .manual_sw_b(man[1]), .access_enable(access_enable), .sensor_byp_req(br[3]),
        .sensor_byp_clr(br[2]), .sensor_byp_div(bd), .vote_byp_req(br[1]),
        .vote_byp_clr(br[0]), .vote_byp_div(bd), .sp_wr(sp_wr), .sp_idx(sp_idx),
        .sp_data(sp_data), .test_trip(tt), .operator_reset(operator_reset), .act(act),
        .div_tripped(div_tripped), .sensor_byp_state(sbs), .vote_byp_state(vbs),
        .byp_rejected(byp_rejected), .full_scram(full_scram));
    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        checked++;
        if (s !== e)
        begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", n, e, s);
        end
    endtask
    task end_of_test();
        if (n_mismatch == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    function automatic logic exp_f();
        logic en;
        en = (var_i == 4'h5 || var_i == 4'h6) ? pwr :
            (var_i == 4'h8) ? mode == rtc_pkg::MODE_RUN : 1'b1;
        return ($countones(mask & ~sb) >= 2 && en) || man == 2'h3
            || mode == rtc_pkg::MODE_SHUTDOWN || $countones(~pok) >= 2;
    endfunction
    task clr();
        {mask, man, tt, pok, mode, pwr} = {14'h000F, rtc_pkg::MODE_RUN, 1'b1};
        repeat (8) @(negedge ref_clk);
        operator_reset = 1'b1;
        for (int i = 0; i < 40 && (full_scram !== 1'b0 || div_tripped !== 4'h0); i++)
            @(negedge ref_clk);
        operator_reset = 1'b0;
        chk("cleared", 8'({full_scram, div_tripped}), 8'h00);
    endtask
    task go();
        repeat (8) @(negedge ref_clk);
        chk("full_scram", 8'(full_scram), 8'(exp_f()));
        if (man == 2'h0 && mode != rtc_pkg::MODE_SHUTDOWN)
            chk("div_tripped", 8'(div_tripped), 8'({4{exp_f()}}));
        clr();
    endtask
    task pulse(input logic [3:0] b, input logic [1:0] d, input logic rej);
        br = b;
        bd = d;
        @(negedge ref_clk);
        br = 4'h0;
        chk("byp_rejected", 8'(byp_rejected), 8'(rej));
        @(negedge ref_clk);
    endtask
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        n_mismatch++;
        end_of_test();
    end
    initial
    begin
        void'($urandom(32'h7CF8));
        repeat (6) @(negedge ref_clk);
        rst = 1'b0;
        access_enable = 1'b1;
        for (int i = 0; i < 20; i++)
        begin
            {sp_wr, sp_idx} = {1'b1, 5'(i)};
            sp_data = rtc_pkg::AN_HIGH_TRIP[i % 5] ? 16'h8000 : 16'h4000;
            @(negedge ref_clk);
        end
        sp_wr = 1'b0;
        clr();
        for (int v = 0; v < 10; v++)
        begin
            {var_i, mask} = {4'(v), 4'h3};
            go();
        end
        {pwr, var_i, mask} = 9'h05F;
        go();
        {pwr, var_i, mask} = 9'h06F;
        go();
        {mode, var_i, mask} = 12'h28F;
        go();
        man = 2'h1;
        go();
        man = 2'h3;
        go();
        mode = rtc_pkg::MODE_SHUTDOWN;
        go();
        pok = 4'hC;
        go();
        for (int i = 0; i < 12; i++)
        begin
            {var_i, mask, pwr, man} = {4'($urandom_range(9)), 7'($urandom)};
            mode = $urandom_range(1) ? rtc_pkg::MODE_RUN : 4'h2;
            go();
        end
        access_enable = 1'b0;
        pulse(4'h8, 2'h0, 1'b1);
        access_enable = 1'b1;
        pulse(4'h8, 2'h0, 1'b0);
        pulse(4'h8, 2'h1, 1'b1);
        chk("sensor_byp", 8'(sbs), 8'h01);
        {sb, var_i, mask} = 12'h103;
        go();
        mask = 4'h6;
        go();
        pulse(4'h4, 2'h0, 1'b0);
        sb = 4'h0;
        chk("sensor_byp", 8'(sbs), 8'h00);
        pulse(4'h2, 2'h2, 1'b0);
        pulse(4'h2, 2'h3, 1'b1);
        chk("vote_byp", 8'(vbs), 8'h04);
        tt = 4'hC;
        repeat (8) @(negedge ref_clk);
        chk("full_scram", 8'(full_scram), 8'h00);
        tt = 4'h0;
        repeat (4) @(negedge ref_clk);
        chk("div_tripped", 8'(div_tripped), 8'h0C);
        clr();
        pulse(4'h1, 2'h2, 1'b0);
        chk("vote_byp", 8'(vbs), 8'h00);
        end_of_test();
    end
endmodule
`default_nettype wire
